// File: core/sysctl_upper.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module sysctl_upper #(
   parameter logic [63:0] FEAT_MASK  = 64'hf3ff_fffa_0000_0000,
   parameter bit          HAS_TAG3   = 1'b0,
   parameter int          DELAY_W    = 24
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [1:0]  cur_level,
   output logic [31:0]      rdata,
   output logic             undef_access,
   input  wire logic        host_hypervisor_bit,
   input  wire logic        general_trap_bit,
   input  wire logic        scr_tag_enable,
   input  wire logic        hyp_tag_enable,
   input  wire logic        priv_access_never,
   input  wire logic        tag_faults_sync,
   input  wire logic        exc_entry_l1,
   input  wire logic        acc_impl_l0,
   input  wire logic        acc_tp2_l0,
   input  wire logic        exec_ls64_l0,
   input  wire logic        exec_store_64_byte_status_accdata_l0,
   input  wire logic        exec_store_64_byte_status_l0,
   input  wire logic        wfe_trap_req,
   output logic             trap_take,
   output logic             trap_to_l2,
   output logic [5:0]       trap_class,
   output logic [24:0]      trap_syndrome,
   output logic             wfe_trap_take,
   output logic [31:0]      ctrl32_view,
   output logic [29:0]      ctrl_eff_hi,
   output logic             mem_copy_set_enable,
   output logic             sp_acts_as_mask,
   output logic             entry_allint,
   output logic             entry_store_bypass_safe,
   output logic             entry_sync_tag_faults,
   output logic             enhanced_priv_access_never_fault_enable
);
   import sysctl_pkg::*;

   if (DELAY_W < 24) begin : g_width_check
      $error("DELAY_W too small for largest delay");
   end

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   logic [63:0] ctrl_r;        // [R2]
   logic [63:0] scr_r;
   logic [63:0] ctrl_nxt;
   logic [63:0] scr_nxt;
   logic [DELAY_W-1:0] wait_cnt_r;
   logic               wait_busy_r;

   wire logic  pair_host    = host_hypervisor_bit & general_trap_bit;
   wire logic  at_l3        = (cur_level == EL3);
   wire logic  scr_hit      = (addr == ADDR_SCR_LO) | (addr == ADDR_SCR_HI);
   wire logic  scr_denied   = scr_hit & (wr | rd) & ~at_l3;  // [R1]
   wire logic  [63:0] wmask = UPPER_WMASK & FEAT_MASK | 64'h0000_0000_ffff_ffff;  // [R25]
   wire logic  [1:0]  tcf1_w = wdata[B_TCF1_LO-32+:2];
   wire logic  [1:0]  tag_fault_mode_l0_w = wdata[B_TAG_FAULT_MODE_L0_LO-32+:2];
   // Reserved tag fault encodings are dropped, keeping the old field value
   wire logic  tcf1_bad     = ~HAS_TAG3 & (tcf1_w == TCF_RSVD);  // [R19]
   wire logic  tag_fault_mode_l0_bad     = ~HAS_TAG3 & (tag_fault_mode_l0_w == TCF_RSVD);
   wire logic  [31:0] hi_keep = {22'h0, tcf1_bad, tcf1_bad, tag_fault_mode_l0_bad, tag_fault_mode_l0_bad, 6'h0};
   wire logic  [31:0] hi_mask = wmask[63:32] & ~hi_keep;
   wire logic  [31:0] hi_new  = (ctrl_r[63:32] & ~hi_mask) | (wdata & hi_mask);
   wire logic  [31:0] lo_new  = (ctrl_r[31:0] & ~wmask[31:0]) | (wdata & wmask[31:0]);

   always_comb begin
      ctrl_nxt = ctrl_r;
      scr_nxt  = scr_r;
      if (wr && addr == ADDR_CTRL_LO) begin
         ctrl_nxt[31:0] = lo_new;  // [R3]
      end else if (wr && addr == ADDR_CTRL_HI) begin
         ctrl_nxt[63:32] = hi_new;
      end else if (wr && addr == ADDR_SCR_LO && at_l3) begin
         scr_nxt[31:0] = wdata;  // [R1]
      end else if (wr && addr == ADDR_SCR_HI && at_l3) begin
         scr_nxt[63:32] = wdata;
      end
   end

   // Reset clears all fields; zero is a legal choice where reset is unknown
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET;  // [R6] [R23]
         scr_r  <= 64'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         scr_r  <= scr_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   wire logic [31:0] rd_mux =
      (addr == ADDR_CTRL_LO) ? ctrl_r[31:0] :
      (addr == ADDR_CTRL_HI) ? ctrl_r[63:32] :
      (addr == ADDR_SCR_LO && at_l3) ? scr_r[31:0] :
      (addr == ADDR_SCR_HI && at_l3) ? scr_r[63:32] : 32'h0;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata        <= 32'h0;
         undef_access <= 1'b0;
      end else begin
         rdata        <= rd ? rd_mux : 32'h0;
         undef_access <= scr_denied;  // [R1]
      end
   end

   // ----------------------------------------------------------------
   // Trap decision, priority ordered
   // ----------------------------------------------------------------
   wire logic t_impl  = acc_impl_l0 & ctrl_r[B_IMPL_TRAP] & ~pair_host;  // [R4]
   // Enable bit clear means the access traps
   wire logic t_tp2   = acc_tp2_l0 & ~ctrl_r[B_TP2] & ~pair_host;         // [R7]
   wire logic t_als   = exec_ls64_l0 & ~ctrl_r[B_ALS] & ~pair_host;       // [R9]
   wire logic t_as0   = exec_store_64_byte_status_accdata_l0 & ~ctrl_r[B_AS0] & ~pair_host;    // [R10]
   wire logic t_asr   = exec_store_64_byte_status_l0 & ~ctrl_r[B_ASR] & ~pair_host;     // [R11]

   wire logic [5:0]  cls_n =
      t_impl ? EC_SYSREG : t_tp2 ? EC_SYSREG : EC_LS64;
   wire logic [24:0] iss_n =
      (t_impl | t_tp2) ? 25'h0 : t_als ? ISS_ALS : t_as0 ? ISS_AS0 : ISS_ASR;
   wire logic any_trap = t_impl | t_tp2 | t_als | t_as0 | t_asr;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         trap_take     <= 1'b0;
         trap_to_l2    <= 1'b0;
         trap_class    <= 6'h0;
         trap_syndrome <= 25'h0;
      end else begin
         trap_take     <= any_trap;
         trap_to_l2    <= ~t_impl & t_tp2 & general_trap_bit;  // [R7]
         trap_class    <= any_trap ? cls_n : 6'h0;
         trap_syndrome <= any_trap ? iss_n : 25'h0;
      end
   end

   // ----------------------------------------------------------------
   // Delayed wait-for-event trap
   // ----------------------------------------------------------------
   wire logic [3:0] del_f = ctrl_r[B_DEL_HI:B_DEL_LO];
   wire logic [4:0] del_sh = {1'b0, del_f} + 5'(DELAY_BIAS);
   wire logic [DELAY_W-1:0] del_len = DELAY_W'(1) << del_sh;  // [R14]
   wire logic del_on   = ctrl_r[B_DEL_EN];                        // [R15]
   wire logic cnt_done = wait_busy_r & (wait_cnt_r >= del_len - DELAY_W'(1));
   wire logic wfe_fire = wfe_trap_req & (~del_on | cnt_done);

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wait_cnt_r    <= '0;
         wait_busy_r   <= 1'b0;
         wfe_trap_take <= 1'b0;
      end else begin
         wfe_trap_take <= wfe_fire;
         if (!wfe_trap_req || wfe_fire) begin
            wait_busy_r <= 1'b0;
            wait_cnt_r  <= '0;
         end else if (del_on) begin
            wait_busy_r <= 1'b1;
            wait_cnt_r  <= wait_busy_r ? wait_cnt_r + DELAY_W'(1) : '0;  // [R14]
         end
      end
   end

   // ----------------------------------------------------------------
   // Effective control outputs
   // ----------------------------------------------------------------
   logic [29:0] eff_nxt;
   always_comb begin
      eff_nxt = ctrl_r[63:34];
      eff_nxt[B_TRANSACTIONAL_MEM_ENABLE_L0-34] = ctrl_r[B_TRANSACTIONAL_MEM_ENABLE_L0] & ~pair_host;               // [R12]
      eff_nxt[B_TRIVIAL_TRANSACT_L0-34] = ctrl_r[B_TRIVIAL_TRANSACT_L0] & ~pair_host;               // [R13]
      eff_nxt[B_ATA1-34] = ctrl_r[B_ATA1] & scr_tag_enable & hyp_tag_enable;  // [R17]
      eff_nxt[B_ALLOC_TAG_ACCESS_L0-34] = ctrl_r[B_ALLOC_TAG_ACCESS_L0] & scr_tag_enable & hyp_tag_enable
                           & ~pair_host;                                // [R18]
      eff_nxt[B_TAG_FAULT_MODE_L0_LO-34+:2] = pair_host ? 2'h0 : ctrl_r[B_TAG_FAULT_MODE_L0_LO+:2];  // [R20]
      eff_nxt[B_BT0-34]  = ctrl_r[B_BT0] & ~pair_host;                // [R22]
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl32_view             <= 32'h0;
         ctrl_eff_hi             <= 30'h0;
         mem_copy_set_enable     <= 1'b0;
         sp_acts_as_mask         <= 1'b0;
         entry_allint            <= 1'b0;
         entry_store_bypass_safe <= 1'b0;
         entry_sync_tag_faults   <= 1'b0;
         enhanced_priv_access_never_fault_enable       <= 1'b0;
      end else begin
         ctrl32_view         <= ctrl_r[31:0];                        // [R3]
         ctrl_eff_hi         <= eff_nxt;
         mem_copy_set_enable <= ctrl_r[B_MOPS] | pair_host;           // [R24]
         sp_acts_as_mask     <= ctrl_r[B_NMI] & ctrl_r[B_SP_MASK];   // [R5]
         if (exc_entry_l1) begin
            entry_allint            <= ctrl_r[B_NMI] & ~ctrl_r[B_SP_MASK];  // [R5]
            entry_store_bypass_safe <= ctrl_r[B_SSBS];               // [R16]
            entry_sync_tag_faults   <= ~tag_faults_sync & ctrl_r[B_TAG_FAULT_SYNC_ON_ENTRY];  // [R21]
         end
         enhanced_priv_access_never_fault_enable   <= priv_access_never & ctrl_r[B_ENHANCED_PRIV_ACCESS_NEVER];   // [R8]
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_scr_undef;
      @(posedge mclk) disable iff (reset)
      (scr_hit && (wr || rd) && cur_level != EL3) |=> undef_access;
   endproperty
   a_scr_undef: assert property (p_scr_undef) else $error("scr access not undefined"); // [R1]

   property p_scr_hold;
      @(posedge mclk) disable iff (reset)
      (cur_level != EL3) |=> (scr_r == $past(scr_r));
   endproperty
   a_scr_hold: assert property (p_scr_hold) else $error("scr written below l3"); // [R1]

   property p_rsvd_zero;
      @(posedge mclk) disable iff (reset)
      (ctrl_r[59:58] == 2'h0) && (ctrl_r[34] == 1'b0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set"); // [R25]

   property p_impl_trap;
      @(posedge mclk) disable iff (reset)
      (acc_impl_l0 && ctrl_r[B_IMPL_TRAP] && !pair_host)
         |=> trap_take && trap_class == EC_SYSREG;
   endproperty
   a_impl_trap: assert property (p_impl_trap) else $error("impl trap missed"); // [R4]

   property p_tp2_route;
      @(posedge mclk) disable iff (reset)
      (!acc_impl_l0 && acc_tp2_l0 && !ctrl_r[B_TP2] && !pair_host)
         |=> trap_class == EC_SYSREG && trap_to_l2 == $past(general_trap_bit);
   endproperty
   a_tp2_route: assert property (p_tp2_route) else $error("tp2 trap wrong"); // [R7]

   property p_als_iss;
      @(posedge mclk) disable iff (reset)
      (exec_ls64_l0 && !ctrl_r[B_ALS] && !pair_host && !acc_impl_l0 && !acc_tp2_l0)
         |=> trap_class == EC_LS64 && trap_syndrome == ISS_ALS;
   endproperty
   a_als_iss: assert property (p_als_iss) else $error("ls64 syndrome wrong"); // [R9]

   property p_asr_iss;
      @(posedge mclk) disable iff (reset)
      (exec_store_64_byte_status_l0 && !ctrl_r[B_ASR] && !pair_host && !acc_impl_l0 && !acc_tp2_l0
       && !exec_ls64_l0 && !exec_store_64_byte_status_accdata_l0) |=> trap_take && trap_syndrome == ISS_ASR;
   endproperty
   a_asr_iss: assert property (p_asr_iss) else $error("store_64_byte_status syndrome wrong"); // [R11]

   sequence s_delay_min;
      (wfe_trap_req && ctrl_r[B_DEL_EN] && !wait_busy_r && ctrl_r[B_DEL_HI:B_DEL_LO] == 4'h0);
   endsequence
   property p_delay_min;
      @(posedge mclk) disable iff (reset)
      s_delay_min ##1 (ctrl_r[B_DEL_EN] && ctrl_r[B_DEL_HI:B_DEL_LO] == 4'h0)
         |-> !wfe_trap_take [*8];
   endproperty
   a_delay_min: assert property (p_delay_min) else $error("wait trap too early"); // [R14]

   property p_nodelay;
      @(posedge mclk) disable iff (reset)
      (wfe_trap_req && !ctrl_r[B_DEL_EN]) |=> wfe_trap_take;
   endproperty
   a_nodelay: assert property (p_nodelay) else $error("undelayed wait trap missed"); // [R15]

   property p_mops;
      @(posedge mclk) disable iff (reset)
      pair_host |=> mem_copy_set_enable;
   endproperty
   a_mops: assert property (p_mops) else $error("mem copy effective value wrong"); // [R24]

   property p_alloc_tag_access_l0;
      @(posedge mclk) disable iff (reset)
      (pair_host || !scr_tag_enable) |=> !ctrl_eff_hi[B_ALLOC_TAG_ACCESS_L0-34];
   endproperty
   a_alloc_tag_access_l0: assert property (p_alloc_tag_access_l0) else $error("l0 tag access leaked"); // [R18]

   // Independent count of held request cycles, so a broken delay counter shows
   logic [DELAY_W:0] held_r;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         held_r <= '0;
      end else begin
         held_r <= (wfe_trap_req && !wfe_fire) ? held_r + (DELAY_W+1)'(1) : '0;
      end
   end

   property p_delay_floor;
      @(posedge mclk) disable iff (reset)
      (wfe_trap_take && $past(del_on)) |-> $past(held_r >= {1'b0, del_len});
   endproperty
   a_delay_floor: assert property (p_delay_floor) else $error("wait trap delay short"); // [R14]

   property p_view_copy;
      @(posedge mclk) disable iff (reset)
      1'b1 |=> ctrl32_view == $past(ctrl_r[31:0]);
   endproperty
   a_view_copy: assert property (p_view_copy) else $error("32-bit view differs"); // [R3]

   property p_entry_allint;
      @(posedge mclk) disable iff (reset)
      exc_entry_l1 |=> entry_allint == $past(ctrl_r[B_NMI] & ~ctrl_r[B_SP_MASK]);
   endproperty
   a_entry_allint: assert property (p_entry_allint) else $error("entry mask wrong"); // [R5]

   property p_nmi_reset;
      @(posedge mclk) reset |-> !ctrl_r[B_NMI];
   endproperty
   a_nmi_reset: assert property (p_nmi_reset) else $error("nmi enable set in reset"); // [R6]

   property p_as0_iss;
      @(posedge mclk) disable iff (reset)
      (exec_store_64_byte_status_accdata_l0 && !ctrl_r[B_AS0] && !pair_host && !acc_impl_l0 && !acc_tp2_l0
       && !exec_ls64_l0) |=> trap_take && trap_syndrome == ISS_AS0;
   endproperty
   a_as0_iss: assert property (p_as0_iss) else $error("accdata syndrome wrong"); // [R10]

   property p_tm0;
      @(posedge mclk) disable iff (reset)
      pair_host |=> !ctrl_eff_hi[B_TRANSACTIONAL_MEM_ENABLE_L0-34];
   endproperty
   a_tm0: assert property (p_tm0) else $error("l0 transactions leaked"); // [R12]

   property p_tmt;
      @(posedge mclk) disable iff (reset)
      !pair_host |=> ctrl_eff_hi[B_TMT1-34:B_TRIVIAL_TRANSACT_L0-34] == $past(ctrl_r[B_TMT1:B_TRIVIAL_TRANSACT_L0]);
   endproperty
   a_tmt: assert property (p_tmt) else $error("trivial transaction bits wrong"); // [R13]

   property p_ssbs;
      @(posedge mclk) disable iff (reset)
      exc_entry_l1 |=> entry_store_bypass_safe == $past(ctrl_r[B_SSBS]);
   endproperty
   a_ssbs: assert property (p_ssbs) else $error("entry bypass state wrong"); // [R16]

   property p_ata1;
      @(posedge mclk) disable iff (reset)
      !(scr_tag_enable && hyp_tag_enable) |=> !ctrl_eff_hi[B_ATA1-34];
   endproperty
   a_ata1: assert property (p_ata1) else $error("l1 tag access leaked"); // [R17]

   property p_tcf_rsvd;
      @(posedge mclk) disable iff (reset)
      !HAS_TAG3 |-> (ctrl_r[B_TCF1_LO+:2] != TCF_RSVD)
                    && (ctrl_r[B_TAG_FAULT_MODE_L0_LO+:2] != TCF_RSVD);
   endproperty
   a_tcf_rsvd: assert property (p_tcf_rsvd) else $error("reserved tag mode stored"); // [R19]

   property p_tag_fault_mode_l0_host;
      @(posedge mclk) disable iff (reset)
      pair_host |=> ctrl_eff_hi[B_TAG_FAULT_MODE_L0_LO-34+:2] == 2'h0;
   endproperty
   a_tag_fault_mode_l0_host: assert property (p_tag_fault_mode_l0_host) else $error("l0 tag mode leaked"); // [R20]

   property p_tag_fault_sync_on_entry;
      @(posedge mclk) disable iff (reset)
      (exc_entry_l1 && tag_faults_sync) |=> !entry_sync_tag_faults;
   endproperty
   a_tag_fault_sync_on_entry: assert property (p_tag_fault_sync_on_entry) else $error("tag sync while synchronous"); // [R21]

   property p_bt0;
      @(posedge mclk) disable iff (reset)
      pair_host |=> !ctrl_eff_hi[B_BT0-34];
   endproperty
   a_bt0: assert property (p_bt0) else $error("l0 branch compat leaked"); // [R22]
endmodule // sysctl_upper

// File: inc/sysctl_pkg.sv
// Summary of operation
// [R1] Secure configuration register access is undefined below level 3, performed at level 3.
// [R2] Level-1 system control register is 64 bits wide.
// [R3] Low 32 bits are shared with the 32-bit state control view.
// [R4] Bit 63 traps level-0 implementation-specific accesses unless host pair is both 1.
// [R5] Bit 62 with NMI enable decides stack-select masking and entry mask value.
// [R6] NMI enable sits at bit 61 and clears on warm reset.
// [R7] Bit 60 traps level-0 matrix pointer access, class 0x18, to 1 or 2.
// [R8] Bit 57 decides level-1 data access fault on level-0 executable pages.
// [R9] Bit 56 traps level-0 64-byte load/store, class 0x0a, code 2.
// [R10] Bit 55 traps level-0 store-status accdata, code 1.
// [R11] Bit 54 traps level-0 store-status, code 0.
// [R12] Bits 53 and 52 enable transactions at levels 1 and 0.
// [R13] Bits 51 and 50 force trivial transactions at levels 1 and 0.
// [R14] Delay enabled: wait at least 2^(field+8) cycles before wait trap.
// [R15] Bit 45 enables the delayed wait trap; zero means no delay.
// [R16] Exception entry loads store-bypass-safe state from bit 44.
// [R17] Bit 43 controls level-1 tag access when both higher enables set.
// [R18] Bit 42 controls level-0 tag access, higher enables set, pair not both.
// [R19] Bits 41:40 select level-1 tag fault effect; 0b11 reserved without rev3.
// [R20] Bits 39:38 select level-0 tag fault effect unless pair is both 1.
// [R21] Bit 37 syncs pending async tag faults on entry to level 1.
// [R22] Bits 36 and 35 select branch type compatibility at levels 1 and 0.
// [R23] Fields without defined reset value reset to an arbitrary value.
// [R24] Bit 33 enables level-0 memory copy/set; effective 1 when pair both 1.
// [R25] Absent features and reserved bits 59:58, 34 read zero, ignore writes.
package sysctl_pkg;
   // ----------------------------------------------------------------
   // Register addressing
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL_LO  = 4'h0;
   localparam logic [3:0] ADDR_CTRL_HI  = 4'h4;
   localparam logic [3:0] ADDR_SCR_LO   = 4'h8;
   localparam logic [3:0] ADDR_SCR_HI   = 4'hc;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int B_IMPL_TRAP  = 63;
   localparam int B_SP_MASK    = 62;
   localparam int B_NMI        = 61;
   localparam int B_TP2        = 60;
   localparam int B_ENHANCED_PRIV_ACCESS_NEVER       = 57;
   localparam int B_ALS        = 56;
   localparam int B_AS0        = 55;
   localparam int B_ASR        = 54;
   localparam int B_TME1       = 53;
   localparam int B_TRANSACTIONAL_MEM_ENABLE_L0       = 52;
   localparam int B_TMT1       = 51;
   localparam int B_TRIVIAL_TRANSACT_L0       = 50;
   localparam int B_DEL_HI     = 49;
   localparam int B_DEL_LO     = 46;
   localparam int B_DEL_EN     = 45;
   localparam int B_SSBS       = 44;
   localparam int B_ATA1       = 43;
   localparam int B_ALLOC_TAG_ACCESS_L0       = 42;
   localparam int B_TCF1_LO    = 40;
   localparam int B_TAG_FAULT_MODE_L0_LO    = 38;
   localparam int B_TAG_FAULT_SYNC_ON_ENTRY      = 37;
   localparam int B_BT1        = 36;
   localparam int B_BT0        = 35;
   localparam int B_MOPS       = 33;
   localparam int DELAY_BIAS   = 8;
   // ----------------------------------------------------------------
   // Reset and writable masks
   // ----------------------------------------------------------------
   localparam logic [63:0] CTRL_RESET   = 64'h0000_0000_0000_0000;
   localparam logic [63:0] UPPER_WMASK  = 64'hf3ff_fffa_0000_0000;
   localparam logic [1:0]  TCF_RSVD     = 2'h3;
   // ----------------------------------------------------------------
   // Trap reporting
   // ----------------------------------------------------------------
   localparam logic [5:0]  EC_SYSREG    = 6'h18;
   localparam logic [5:0]  EC_LS64      = 6'h0a;
   localparam logic [24:0] ISS_ALS      = 25'h0000002;
   localparam logic [24:0] ISS_AS0      = 25'h0000001;
   localparam logic [24:0] ISS_ASR      = 25'h0000000;
   localparam logic [1:0]  EL0 = 2'h0;
   localparam logic [1:0]  EL3 = 2'h3;
endpackage

// File: verif/test_el1_system_control_upper_fields.sv
`timescale 1ns/1ns
module test_el1_system_control_upper_fields;
   import sysctl_pkg::*;
   logic        mclk, reset, wr, rd, hh, gt, scr_tag, hyp_tag, pan, tfs, exc, wfe;
   logic        a_impl, a_tp2, x_ls, x_bv0, x_bv;
   logic [3:0]  addr;
   logic [31:0] wdata, d;
   logic [29:0] eh;
   logic [1:0]  lvl;
   logic [63:0] m_ctrl, m_scr;
   int          err_total, tests_run, cycles, seed, i;
   logic [24:0] syn [5] = '{25'h0, 25'h0, ISS_ALS, ISS_AS0, ISS_ASR};
   sysctl_upper dut_u (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .cur_level(lvl), .rdata(), .undef_access(), .host_hypervisor_bit(hh),
      .general_trap_bit(gt), .scr_tag_enable(scr_tag), .hyp_tag_enable(hyp_tag),
      .priv_access_never(pan), .tag_faults_sync(tfs), .exc_entry_l1(exc),
      .acc_impl_l0(a_impl), .acc_tp2_l0(a_tp2), .exec_ls64_l0(x_ls),
      .exec_store_64_byte_status_accdata_l0(x_bv0), .exec_store_64_byte_status_l0(x_bv), .wfe_trap_req(wfe), .trap_take(),
      .trap_to_l2(), .trap_class(), .trap_syndrome(), .wfe_trap_take(), .ctrl32_view(),
      .ctrl_eff_hi(), .mem_copy_set_enable(), .sp_acts_as_mask(), .entry_allint(),
      .entry_store_bypass_safe(), .entry_sync_tag_faults(), .enhanced_priv_access_never_fault_enable());
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // Checking and reporting
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(string nm, logic [63:0] exp, logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, got);
         err_total++;
      end
   endtask
   // Hang guard: the longest delayed trap needs about 512 cycles
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         err_total++;
         give_verdict();
      end
   end
   // ----------------------------------------------------------------
   // Register bus and model
   // ----------------------------------------------------------------
   function automatic logic [31:0] upd_hi(logic [31:0] o, logic [31:0] w);
      logic [31:0] n;
      n = (o & ~UPPER_WMASK[63:32]) | (w & UPPER_WMASK[63:32]);
      // A reserved tag fault encoding leaves the field unchanged
      if (n[9:8] == 2'h3) n[9:8] = o[9:8];
      if (n[7:6] == 2'h3) n[7:6] = o[7:6];
      return n;
   endfunction
   task automatic acc(bit w, logic [3:0] a, logic [31:0] dv);
      logic [31:0] e;
      logic        u;
      @(posedge mclk);
      u = a[3] && (lvl != 2'h3);
      e = a[3] ? (u ? 32'h0 : (a[2] ? m_scr[63:32] : m_scr[31:0]))
               : (a[2] ? m_ctrl[63:32] : m_ctrl[31:0]);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= dv;
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("undef_access", u, dut_u.undef_access);
      if (!w) chk("rdata", e, dut_u.rdata);
      else if (a == ADDR_CTRL_HI) m_ctrl[63:32] = upd_hi(m_ctrl[63:32], dv);
      else if (a == ADDR_CTRL_LO) m_ctrl[31:0] = dv;
      else if (!u && a[2]) m_scr[63:32] = dv;
      else if (!u) m_scr[31:0] = dv;
   endtask
   task automatic settle();
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic trap(int k, bit et, bit l2);
      @(posedge mclk);
      {a_impl, a_tp2, x_ls, x_bv0, x_bv} <= 5'h10 >> k;
      @(posedge mclk);
      {a_impl, a_tp2, x_ls, x_bv0, x_bv} <= 5'h0;
      #1;
      chk("trap_take", et, dut_u.trap_take);
      if (et) chk("trap_class", k < 2 ? EC_SYSREG : EC_LS64, dut_u.trap_class);
      if (et && k != 1) chk("trap_syndrome", syn[k], dut_u.trap_syndrome);
      if (et && k == 1) chk("trap_to_l2", l2, dut_u.trap_to_l2);
   endtask
   task automatic wfe_run(int pre, int lo, int hi);
      int n;
      n = 0;
      if (pre > 0) begin
         @(posedge mclk) wfe <= 1'b1;
         repeat (pre) @(posedge mclk);
         wfe <= 1'b0;
      end
      @(posedge mclk) wfe <= 1'b1;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (dut_u.wfe_trap_take !== 1'b1 && n < 2000);
      chk("wfe_delay_in_range", 1, n >= lo && n <= hi);
      @(posedge mclk) wfe <= 1'b0;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h70ee2d40;
      {reset, wr, rd, hh, gt, pan, tfs, exc, wfe, a_impl, a_tp2, x_ls, x_bv0, x_bv} = '0;
      {scr_tag, hyp_tag} = 2'h3;
      addr = 4'h0;
      wdata = 32'h0;
      lvl = 2'h1;
      m_ctrl = 64'h0;
      m_scr = 64'h0;
      reset = 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      for (i = 0; i < 4; i++) acc(0, 4'(i * 4), 32'h0);
      acc(1, ADDR_CTRL_HI, 32'hffff_ffff);
      acc(0, ADDR_CTRL_HI, 32'h0);
      for (i = 0; i < 8; i++) begin
         acc(1, ADDR_CTRL_HI, $random(seed));
         acc(0, ADDR_CTRL_HI, 32'h0);
         settle();
         chk("ctrl_eff_hi", m_ctrl[63:34], dut_u.ctrl_eff_hi);
      end
      d = $random(seed);
      acc(1, ADDR_CTRL_LO, d);
      acc(0, ADDR_CTRL_LO, 32'h0);
      settle();
      chk("ctrl32_view", d, dut_u.ctrl32_view);
      for (i = 0; i < 4; i++) begin
         @(posedge mclk) lvl <= 2'(i);
         acc(1, ADDR_SCR_LO, $random(seed));
         acc(1, ADDR_SCR_HI, $random(seed));
         acc(0, ADDR_SCR_LO, 32'h0);
         acc(0, ADDR_SCR_HI, 32'h0);
      end
      @(posedge mclk) lvl <= 2'h1;
      for (i = 0; i < 8; i++) begin
         acc(1, ADDR_CTRL_HI, $random(seed));
         @(posedge mclk);
         pan <= i[0];
         hh <= i[1];
         gt <= i[1];
         tfs <= i[2];
         scr_tag <= ~(i[0] & i[2]);
         hyp_tag <= ~(i[1] & i[2]);
         settle();
         // Model of the gating: host pair hides level-0 controls, tag enables gate access
         eh = m_ctrl[63:34];
         eh[9] = eh[9] & scr_tag & hyp_tag;
         eh[8] = eh[8] & scr_tag & hyp_tag & ~hh;
         if (hh) {eh[18], eh[16], eh[5:4], eh[1]} = 5'h0;
         chk("ctrl_eff_hi_gated", eh, dut_u.ctrl_eff_hi);
         chk("enhanced_priv_access_never", m_ctrl[57] & pan, dut_u.enhanced_priv_access_never_fault_enable);
         chk("sp_mask", m_ctrl[61] & m_ctrl[62], dut_u.sp_acts_as_mask);
         chk("mem_copy", m_ctrl[33] | hh, dut_u.mem_copy_set_enable);
         @(posedge mclk) exc <= 1'b1;
         @(posedge mclk) exc <= 1'b0;
         #1;
         chk("entry_ssbs", m_ctrl[44], dut_u.entry_store_bypass_safe);
         chk("entry_sync", m_ctrl[37] & ~tfs, dut_u.entry_sync_tag_faults);
         chk("entry_allint", m_ctrl[61] & ~m_ctrl[62], dut_u.entry_allint);
      end
      @(posedge mclk) {hh, gt} <= 2'h0;
      acc(1, ADDR_CTRL_HI, 32'h8000_0000);
      for (i = 0; i < 5; i++) trap(i, 1, 0);
      @(posedge mclk) gt <= 1'b1;
      trap(1, 1, 1);
      @(posedge mclk) hh <= 1'b1;
      trap(0, 0, 0);
      trap(1, 0, 0);
      @(posedge mclk) {hh, gt} <= 2'h0;
      acc(1, ADDR_CTRL_HI, 32'h11c0_0000);
      for (i = 0; i < 5; i++) trap(i, 0, 0);
      acc(1, ADDR_CTRL_HI, 32'h0000_2000);
      wfe_run(0, 256, 259);
      wfe_run(200, 256, 259);
      acc(1, ADDR_CTRL_HI, 32'h0000_6000);
      wfe_run(0, 512, 515);
      acc(1, ADDR_CTRL_HI, 32'h0003_c000);
      wfe_run(0, 1, 2);
      give_verdict();
   end
endmodule // test_el1_system_control_upper_fields
